// >>> exch_pkg.sv
// shared constants for the controller exchange area and addressed memory
`default_nettype none
package exch_pkg;
  localparam int DW = 16;
  localparam int XA_W = 10;
  localparam int MA_W = 13;
  localparam logic [9:0] WORDS_PER_UNIT = 10'h00a;
  // exchange area shape, four-axis and two-axis variants
  localparam logic [5:0] AREA4 = 6'h32;
  localparam logic [5:0] CMD4 = 6'h12;
  localparam logic [5:0] STAT4 = 6'h1e;
  localparam logic [5:0] AREA2 = 6'h1e;
  localparam logic [5:0] CMD2 = 6'h0a;
  localparam logic [5:0] STAT2 = 6'h10;
  localparam logic [2:0] AXES4 = 3'h4;
  localparam logic [2:0] AXES2 = 3'h2;
  localparam int CMD_MAX = 18;
  localparam int STAT_MAX = 30;
  // command word layout
  localparam int CW_CTRL = 0;
  localparam int CW_JOG = 1;
  localparam int CB_SAVE = 0;
  localparam int CB_DECEL = 1;
  localparam int CB_PROT_SET = 2;
  localparam int CB_PROT_CLR = 3;
  localparam int CB_ABS_ORG = 4;
  localparam int CB_START = 5;
  localparam int CB_SINGLE = 6;
  localparam int CB_ERR_RST = 7;
  localparam int JB_DIR = 4;
  // status word layout
  localparam int SW_FLAGS = 0;
  localparam int SW_JOG = 1;
  localparam int SW_POS = 2;
  localparam int SW_BLK = 6;
  localparam int SB_RUN = 0;
  localparam int SB_SINGLE = 1;
  localparam int SB_DECEL = 2;
  localparam int SB_SAVING = 3;
  localparam int SB_LOADING = 4;
  localparam int SB_PROT = 5;
  localparam int SB_JOG_REF = 6;
  localparam int SB_ORIGIN = 7;
  // internal memory map, word addresses
  localparam logic [12:0] POS_ENTRIES = 13'h07d0;
  localparam logic [12:0] ENTRY_WORDS = 13'h0003;
  localparam logic [12:0] POS_WORDS = 13'h1770;
  localparam logic [12:0] PARAM_BASE = 13'h1770;
  localparam logic [12:0] PROG_BASE = 13'h17f0;
  localparam logic [12:0] STORE_WORDS = 13'h18f0;
  localparam int STORE_N = 6384;
  localparam logic [12:0] OVR_ADDR = 13'h17e8;
  localparam logic [12:0] MON_BASE = 13'h1900;
  localparam logic [12:0] MON_WORDS = 13'h0010;
  localparam logic [12:0] CMD_PTR = 13'h1a00;
  localparam logic [12:0] CMD_DATA = 13'h1a01;
  localparam logic [15:0] OVR_MIN_VER = 16'h0115;
  localparam logic [7:0] DECEL_CYC = 8'h10;
endpackage : exch_pkg
`default_nettype wire

// >>> exch_if.sv
// exchange link between controller cpu and motion module
`default_nettype none
interface exch_if;
  import exch_pkg::*;
  logic refresh;
  logic xch_wr;
  logic xch_rd;
  logic [XA_W-1:0] xch_addr;
  logic [DW-1:0] xch_wdata;
  logic [DW-1:0] xch_rdata;
  logic mem_wr;
  logic mem_rd;
  logic [MA_W-1:0] mem_addr;
  logic [DW-1:0] mem_wdata;
  logic [DW-1:0] mem_rdata;
  modport dev (
    input refresh, xch_wr, xch_rd, xch_addr, xch_wdata, mem_wr, mem_rd, mem_addr, mem_wdata,
    output xch_rdata, mem_rdata
  );
  modport cpu (
    output refresh, xch_wr, xch_rd, xch_addr, xch_wdata, mem_wr, mem_rd, mem_addr, mem_wdata,
    input xch_rdata, mem_rdata
  );
endinterface : exch_if
`default_nettype wire

// >>> exch_dev.sv
// motion module end: exchange words, addressed memory, flash copy, motion state
`default_nettype none
// Behaviour
// - area 50 or 30 words from unit base
// - four-axis: 18 command words refreshed in
// - four-axis: 30 status words refreshed out
// - four-axis: words n+48, n+49 reserved
// - two-axis: 10 command words refreshed in
// - two-axis: 16 status words refreshed out
// - two-axis: words n+26 to n+29 reserved
// - two-axis: no third, fourth axis data
// - internal data read/written by address
// - monitor data is read-only
// - command area writes load position data
// - save copies parameters, positions, programs only
// - reload flash at every power-up/restart
// - position entries A0000 to A1999 addressable
// - word 6120 only on enhanced 1.15+
// - cpu sets word count before transfers
// - jog one axis only, refuse several
// - decel stop halts axes and program
// - protection blocks position/parameter changes
// - absolute origin sets position zero
// - single block: one block per start
// - indirect load up to 2000 entries
module exch_dev
  import exch_pkg::*;
#(
  parameter bit FOUR_AXIS = 1'b1,
  parameter bit ENHANCED = 1'b1,
  parameter logic [15:0] UNIT_VER = 16'h0115
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] unit_sw_i,
  exch_if.dev bus
);
  localparam logic [5:0] AREA_N = FOUR_AXIS ? AREA4 : AREA2;
  localparam logic [5:0] CMD_N = FOUR_AXIS ? CMD4 : CMD2;
  localparam logic [5:0] STAT_N = FOUR_AXIS ? STAT4 : STAT2;
  localparam logic [2:0] AXES_N = FOUR_AXIS ? AXES4 : AXES2;
  localparam bit OVR_OK = ENHANCED && (UNIT_VER >= OVR_MIN_VER);

  typedef enum logic [1:0] {CP_LOAD, CP_IDLE, CP_SAVE} copy_state_t;

  logic [3:0] unit_s1_reg;
  logic [3:0] unit_s2_reg;
  logic [9:0] base;
  logic [9:0] off;
  logic in_area;
  logic [DW-1:0] cmd_reg [CMD_MAX];
  logic [DW-1:0] snap_reg [STAT_MAX];
  logic [DW-1:0] live [STAT_MAX];
  logic [DW-1:0] xch_rdata_reg;
  logic [DW-1:0] ctrl_prev_reg;
  logic [DW-1:0] ctrl_rise;
  logic [DW-1:0] ram [STORE_N];
  logic [DW-1:0] flash [STORE_N];
  copy_state_t cp_state_reg;
  logic [12:0] cp_idx_reg;
  logic [12:0] ptr_reg;
  logic ram_we;
  logic [12:0] ram_wa;
  logic [DW-1:0] mem_rdata_reg;
  logic prot_reg;
  logic run_reg;
  logic single_reg;
  logic [7:0] decel_cnt_reg;
  logic [DW-1:0] blk_cnt_reg;
  logic jog_ref_reg;
  logic origin_reg;
  logic [3:0] axis_mask;
  logic [3:0] jog_req;
  logic jog_many;
  logic jog_ok;
  logic [DW-1:0] pos_reg [4];

  // switch is a pin, so two flops before the base is formed
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      unit_s1_reg <= 4'h0;
      unit_s2_reg <= 4'h0;
    end
    else
    begin
      unit_s1_reg <= unit_sw_i;
      unit_s2_reg <= unit_s1_reg;
    end
  end

  assign base = 10'({6'h00, unit_s2_reg} * WORDS_PER_UNIT);
  assign off = bus.xch_addr - base;
  assign in_area = (bus.xch_addr >= base) && (off < {4'h0, AREA_N});

  // command words only; status and reserved offsets drop the write
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < CMD_MAX; i++)
        cmd_reg[i] <= 16'h0000;
    end
    else if (bus.xch_wr && in_area && off < {4'h0, CMD_N})
    begin
      cmd_reg[off[4:0]] <= bus.xch_wdata;
    end
  end

  always_comb
  begin
    for (int i = 0; i < STAT_MAX; i++)
      live[i] = 16'h0000;
    live[SW_FLAGS][SB_RUN] = run_reg;
    live[SW_FLAGS][SB_SINGLE] = single_reg;
    live[SW_FLAGS][SB_DECEL] = decel_cnt_reg != 8'h00;
    live[SW_FLAGS][SB_SAVING] = cp_state_reg == CP_SAVE;
    live[SW_FLAGS][SB_LOADING] = cp_state_reg == CP_LOAD;
    live[SW_FLAGS][SB_PROT] = prot_reg;
    live[SW_FLAGS][SB_JOG_REF] = jog_ref_reg;
    live[SW_FLAGS][SB_ORIGIN] = origin_reg;
    live[SW_JOG] = {12'h000, jog_req};
    for (int a = 0; a < 4; a++)
      live[SW_POS + a] = (a < int'(AXES_N)) ? pos_reg[a] : 16'h0000;
    live[SW_BLK] = blk_cnt_reg;
  end

  // every status word captured on the same edge
  for (genvar i = 0; i < STAT_MAX; i++)
  begin : g_snap
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
      if (!nrst_i)
        snap_reg[i] <= 16'h0000;
      else if (bus.refresh)
        snap_reg[i] <= live[i];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      xch_rdata_reg <= 16'h0000;
    else if (bus.xch_rd)
    begin
      if (in_area && off < {4'h0, CMD_N})
        xch_rdata_reg <= cmd_reg[off[4:0]];
      else if (in_area && off < {4'h0, CMD_N + STAT_N})
        xch_rdata_reg <= snap_reg[5'(off - {4'h0, CMD_N})];
      else
        xch_rdata_reg <= 16'h0000;
    end
  end
  assign bus.xch_rdata = xch_rdata_reg;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ctrl_prev_reg <= 16'h0000;
    else
      ctrl_prev_reg <= cmd_reg[CW_CTRL];
  end
  assign ctrl_rise = cmd_reg[CW_CTRL] & ~ctrl_prev_reg;

  // reload after every reset, save on command; monitor never copied
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cp_state_reg <= CP_LOAD;
      cp_idx_reg <= 13'h0000;
    end
    else
    begin
      unique case (cp_state_reg)
        CP_LOAD, CP_SAVE:
        begin
          cp_idx_reg <= cp_idx_reg + 13'h0001;
          if (cp_idx_reg == STORE_WORDS - 13'h0001)
          begin
            cp_state_reg <= CP_IDLE;
            cp_idx_reg <= 13'h0000;
          end
        end
        CP_IDLE:
          if (ctrl_rise[CB_SAVE])
            cp_state_reg <= CP_SAVE;
      endcase
    end
  end

  always_comb
  begin
    ram_wa = bus.mem_addr;
    ram_we = 1'b0;
    if (bus.mem_wr && cp_state_reg == CP_IDLE)
    begin
      if (bus.mem_addr == CMD_DATA)
      begin
        ram_wa = ptr_reg;
        ram_we = !prot_reg && ptr_reg < POS_WORDS;
      end
      else if (bus.mem_addr < STORE_WORDS)
      begin
        ram_we = !(prot_reg && bus.mem_addr < PROG_BASE)
          && !(bus.mem_addr == OVR_ADDR && !OVR_OK);
      end
    end
  end

  // arrays carry no reset: flash contents must survive it
  always_ff @(posedge clk_i)
  begin
    if (cp_state_reg == CP_LOAD)
      ram[cp_idx_reg] <= flash[cp_idx_reg];
    else if (ram_we)
      ram[ram_wa] <= bus.mem_wdata;
    if (cp_state_reg == CP_SAVE)
      flash[cp_idx_reg] <= ram[cp_idx_reg];
  end

  // indirect load pointer, entry number times three words
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ptr_reg <= 13'h0000;
    else if (bus.mem_wr && bus.mem_addr == CMD_PTR && cp_state_reg == CP_IDLE)
    begin
      if (bus.mem_wdata[12:0] < POS_ENTRIES)
        ptr_reg <= 13'(bus.mem_wdata[12:0] * ENTRY_WORDS);
    end
    else if (ram_we && bus.mem_addr == CMD_DATA)
      ptr_reg <= ptr_reg + 13'h0001;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      mem_rdata_reg <= 16'h0000;
    else if (bus.mem_rd)
    begin
      if (bus.mem_addr == OVR_ADDR && !OVR_OK)
        mem_rdata_reg <= 16'h0000;
      else if (bus.mem_addr < STORE_WORDS)
        mem_rdata_reg <= ram[bus.mem_addr];
      else if (bus.mem_addr >= MON_BASE && bus.mem_addr < MON_BASE + MON_WORDS)
        mem_rdata_reg <= live[bus.mem_addr[3:0]];
      else if (bus.mem_addr == CMD_PTR)
        mem_rdata_reg <= {3'h0, ptr_reg};
      else
        mem_rdata_reg <= 16'h0000;
    end
  end
  assign bus.mem_rdata = mem_rdata_reg;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      prot_reg <= 1'b0;
    else if (ctrl_rise[CB_PROT_SET])
      prot_reg <= 1'b1;
    else if (ctrl_rise[CB_PROT_CLR])
      prot_reg <= 1'b0;
  end

  // program execution; a block is modelled as one clock step
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      run_reg <= 1'b0;
      single_reg <= 1'b0;
      decel_cnt_reg <= 8'h00;
      blk_cnt_reg <= 16'h0000;
    end
    else if (ctrl_rise[CB_DECEL])
    begin
      run_reg <= 1'b0;
      decel_cnt_reg <= DECEL_CYC;
    end
    else
    begin
      if (decel_cnt_reg != 8'h00)
        decel_cnt_reg <= decel_cnt_reg - 8'h01;
      if (ctrl_rise[CB_START] && !run_reg && decel_cnt_reg == 8'h00)
      begin
        run_reg <= 1'b1;
        single_reg <= cmd_reg[CW_CTRL][CB_SINGLE];
      end
      else if (run_reg)
      begin
        blk_cnt_reg <= blk_cnt_reg + 16'h0001;
        if (single_reg)
          run_reg <= 1'b0;
      end
    end
  end

  assign axis_mask = FOUR_AXIS ? 4'hf : 4'h3;
  assign jog_req = cmd_reg[CW_JOG][3:0] & axis_mask;
  assign jog_many = $countones(jog_req) > 1;
  assign jog_ok = !jog_many && !run_reg && decel_cnt_reg == 8'h00;

  // set wins over the error-reset clear
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      jog_ref_reg <= 1'b0;
      origin_reg <= 1'b0;
    end
    else
    begin
      if (jog_many)
        jog_ref_reg <= 1'b1;
      else if (ctrl_rise[CB_ERR_RST])
        jog_ref_reg <= 1'b0;
      if (ctrl_rise[CB_ABS_ORG])
        origin_reg <= 1'b1;
    end
  end

  for (genvar a = 0; a < 4; a++)
  begin : g_axis
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
      if (!nrst_i)
        pos_reg[a] <= 16'h0000;
      else if (ctrl_rise[CB_ABS_ORG])
        pos_reg[a] <= 16'h0000;
      else if (jog_ok && jog_req[a])
        pos_reg[a] <= cmd_reg[CW_JOG][JB_DIR] ? pos_reg[a] - 16'h0001 : pos_reg[a] + 16'h0001;
    end
  end
endmodule : exch_dev
`default_nettype wire

// >>> exch_cpu.sv
// controller cpu end: refresh sequencer and addressed read/write instructions
`default_nettype none
module exch_cpu
  import exch_pkg::*;
#(
  parameter bit FOUR_AXIS = 1'b1
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] unit_no_i,
  input wire logic [6:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DW-1:0] rdata_o,
  exch_if.cpu bus
);
  localparam logic [5:0] CMD_N = FOUR_AXIS ? CMD4 : CMD2;
  localparam logic [5:0] STAT_N = FOUR_AXIS ? STAT4 : STAT2;
  localparam logic [6:0] R_STAT = 7'h20;
  localparam logic [6:0] R_MADDR = 7'h40;
  localparam logic [6:0] R_WCOUNT = 7'h41;
  localparam logic [6:0] R_MWDATA = 7'h42;
  localparam logic [6:0] R_MRDGO = 7'h43;
  localparam logic [6:0] R_MRDATA = 7'h44;
  localparam logic [6:0] R_CTRL = 7'h45;

  typedef enum logic [1:0] {H_IDLE, H_SNAP, H_CMD, H_STAT} ref_state_t;

  ref_state_t st_reg;
  logic [5:0] idx_reg;
  logic stat_vld_reg;
  logic [4:0] stat_idx_reg;
  logic [DW-1:0] cmd_reg [CMD_MAX];
  logic [DW-1:0] stat_reg [STAT_MAX];
  logic [12:0] maddr_reg;
  logic [12:0] wcount_reg;
  logic [DW-1:0] mrdata_reg;
  logic mrd_pend_reg;
  logic refused_reg;
  logic [DW-1:0] rdata_reg;
  logic [9:0] base;
  logic go_wr;
  logic go_rd;
  logic tx_ok;

  assign base = 10'({6'h00, unit_no_i} * WORDS_PER_UNIT);
  assign bus.refresh = st_reg == H_SNAP;
  assign bus.xch_wr = st_reg == H_CMD;
  assign bus.xch_rd = st_reg == H_STAT;
  assign bus.xch_addr = base + {4'h0, idx_reg};
  assign bus.xch_wdata = cmd_reg[5'(idx_reg)];

  // word count must be loaded before any addressed transfer
  assign tx_ok = wcount_reg != 13'h0000;
  assign go_wr = wr_i && addr_i == R_MWDATA && tx_ok;
  assign go_rd = wr_i && addr_i == R_MRDGO && tx_ok;
  assign bus.mem_wr = go_wr;
  assign bus.mem_rd = go_rd;
  assign bus.mem_addr = maddr_reg;
  assign bus.mem_wdata = wdata_i;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_reg <= H_IDLE;
      idx_reg <= 6'h00;
    end
    else
    begin
      unique case (st_reg)
        H_IDLE:
          if (wr_i && addr_i == R_CTRL && wdata_i[0])
            st_reg <= H_SNAP;
        H_SNAP:
          st_reg <= H_CMD;
        H_CMD:
        begin
          // step on into the status offsets so no command word is read back
          idx_reg <= idx_reg + 6'h01;
          if (idx_reg == CMD_N - 6'h01)
            st_reg <= H_STAT;
        end
        H_STAT:
          if (idx_reg == CMD_N + STAT_N - 6'h01)
          begin
            st_reg <= H_IDLE;
            idx_reg <= 6'h00;
          end
          else
            idx_reg <= idx_reg + 6'h01;
      endcase
    end
  end

  // status read data lands one cycle after its strobe
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      stat_vld_reg <= 1'b0;
      stat_idx_reg <= 5'h00;
    end
    else
    begin
      stat_vld_reg <= bus.xch_rd;
      stat_idx_reg <= 5'(idx_reg - CMD_N);
    end
  end

  for (genvar i = 0; i < STAT_MAX; i++)
  begin : g_stat
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
      if (!nrst_i)
        stat_reg[i] <= 16'h0000;
      else if (stat_vld_reg && stat_idx_reg == 5'(i))
        stat_reg[i] <= bus.xch_rdata;
    end
  end

  for (genvar i = 0; i < CMD_MAX; i++)
  begin : g_cmd
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
      if (!nrst_i)
        cmd_reg[i] <= 16'h0000;
      else if (wr_i && addr_i == 7'(i))
        cmd_reg[i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      maddr_reg <= 13'h0000;
      wcount_reg <= 13'h0000;
      refused_reg <= 1'b0;
      mrd_pend_reg <= 1'b0;
      mrdata_reg <= 16'h0000;
    end
    else
    begin
      mrd_pend_reg <= go_rd;
      if (mrd_pend_reg)
        mrdata_reg <= bus.mem_rdata;
      if (wr_i && addr_i == R_MADDR)
        maddr_reg <= wdata_i[12:0];
      else if ((go_wr || go_rd) && maddr_reg != CMD_DATA)
        maddr_reg <= maddr_reg + 13'h0001;
      if (wr_i && addr_i == R_WCOUNT)
        wcount_reg <= wdata_i[12:0];
      else if (go_wr || go_rd)
        wcount_reg <= wcount_reg - 13'h0001;
      if (wr_i && (addr_i == R_MWDATA || addr_i == R_MRDGO) && !tx_ok)
        refused_reg <= 1'b1;
      else if (wr_i && addr_i == R_CTRL && wdata_i[1])
        refused_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_reg <= 16'h0000;
    else if (rd_i)
    begin
      if (addr_i < 7'(CMD_MAX))
        rdata_reg <= cmd_reg[addr_i[4:0]];
      else if (addr_i >= R_STAT && addr_i < R_STAT + 7'(STAT_MAX))
        rdata_reg <= stat_reg[5'(addr_i - R_STAT)];
      else if (addr_i == R_MADDR)
        rdata_reg <= {3'h0, maddr_reg};
      else if (addr_i == R_WCOUNT)
        rdata_reg <= {3'h0, wcount_reg};
      else if (addr_i == R_MRDATA)
        rdata_reg <= mrdata_reg;
      else if (addr_i == R_CTRL)
        rdata_reg <= {14'h0000, refused_reg, st_reg != H_IDLE};
      else
        rdata_reg <= 16'h0000;
    end
  end
  assign rdata_o = rdata_reg;
endmodule : exch_cpu
`default_nettype wire

// >>> plc_exchange_area_assertions.sv
// concurrent checks on the exchange link between both ends, four-axis shape only
`default_nettype none
module plc_exchange_area_assertions
  import exch_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] unit_no_i,
  input wire logic refresh,
  input wire logic xch_wr,
  input wire logic xch_rd,
  input wire logic [XA_W-1:0] xch_addr,
  input wire logic [DW-1:0] xch_rdata,
  input wire logic mem_rd,
  input wire logic [MA_W-1:0] mem_addr,
  input wire logic [DW-1:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] base;
  assign base = 10'(unit_no_i) * WORDS_PER_UNIT;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  // only the first and last word of each phase are pinned; ranges cover the rest
  sequence cmd_phase;
    xch_wr && xch_addr == base ##17 xch_wr && xch_addr == base + 10'd17;
  endsequence
  sequence stat_phase;
    xch_rd && xch_addr == base + 10'd18 ##29 xch_rd && xch_addr == base + 10'd47;
  endsequence
  a_cmd_phase: assert property (refresh |=> cmd_phase)
    else $error("command words not sent in order");
  a_stat_phase: assert property (refresh |-> ##19 stat_phase)
    else $error("status words not fetched in order");
  a_refresh_gap: assert property (refresh |=> !refresh [*8])
    else $error("snapshot retaken during a refresh");
  a_wr_range: assert property (xch_wr |-> xch_addr >= base && xch_addr < base + 10'd18)
    else $error("exchange write outside command words");
  a_rd_range: assert property (xch_rd |-> xch_addr >= base + 10'd18 && xch_addr < base + 10'd48)
    else $error("exchange read outside status words");
  a_xch_hold: assert property (!xch_rd |=> $stable(xch_rdata))
    else $error("exchange read data moved without a read");
  a_mem_hold: assert property (!mem_rd |=> $stable(mem_rdata))
    else $error("memory read data moved without a read");
  a_mem_unmapped: assert property (mem_rd && mem_addr >= 13'h1910 && mem_addr < 13'h1a00
    |=> mem_rdata == 16'h0000)
    else $error("unmapped memory word not zero");
endmodule : plc_exchange_area_assertions
`default_nettype wire

// >>> test_plc_exchange_area.sv
// self-checking bench: controller end and module end joined over the exchange link
`default_nettype none
module test_plc_exchange_area;
  import exch_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] unit_no = 4'h0;
  logic [6:0] addr = 7'h00;
  logic [DW-1:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic [DW-1:0] rdata;
  logic [31:0] seed = 32'h0000_84a7;
  logic [12:0] ma;
  logic [38:0] exp_q[$];
  logic [38:0] note;
  int fails = 0;
  int checked = 0;
  exch_if link();
  exch_dev exch_dev_inst (.clk_i(clk_i), .nrst_i(nrst_i), .unit_sw_i(unit_no), .bus(link.dev));
  exch_cpu exch_cpu_inst (.clk_i(clk_i), .nrst_i(nrst_i), .unit_no_i(unit_no), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .bus(link.cpu));
  plc_exchange_area_assertions plc_exchange_area_assertions_inst (.clk_i(clk_i),
    .nrst_i(nrst_i), .unit_no_i(unit_no), .refresh(link.refresh), .xch_wr(link.xch_wr),
    .xch_rd(link.xch_rd), .xch_addr(link.xch_addr), .xch_rdata(link.xch_rdata),
    .mem_rd(link.mem_rd), .mem_addr(link.mem_addr), .mem_rdata(link.mem_rdata));
  always #2 clk_i = ~clk_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic close_out;
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic check(input logic [6:0] a, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch reg %h expected %h seen %h", a, exp, seen);
    end
  endtask : check
  task automatic put(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
  endtask : put
  task automatic get(input logic [6:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk_i);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    exp_q.push_back({a, m, e & m});
  endtask : get
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask : idle
  // walk is 49 bus cycles plus the mirror landing
  task automatic refresh_all;
    put(7'h45, 16'h0001);
    idle(56);
  endtask : refresh_all
  task automatic mw(input logic [12:0] a, input logic [15:0] d);
    put(7'h40, {3'h0, a});
    put(7'h41, 16'h0001);
    put(7'h42, d);
  endtask : mw
  task automatic mr(input logic [12:0] a, input logic [15:0] e);
    put(7'h40, {3'h0, a});
    put(7'h41, 16'h0001);
    put(7'h43, 16'h0000);
    idle(3);
    get(7'h44, 16'hffff, e);
  endtask : mr
  // read data lands in the cycle after the strobe and is checked in that cycle only
  always @(posedge clk_i)
  begin
    if (rd_d)
    begin
      note = exp_q.pop_front();
      check(note[38:32], rdata & note[31:16], note[15:0]);
    end
    rd_d <= rd;
  end
  initial
  begin
    repeat (30000) @(posedge clk_i);
    fails++;
    close_out();
  end
  initial
  begin
    seed = xs(seed);
    unit_no = seed[3:0];
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    idle(3);
    get(7'h45, 16'hffff, 16'h0000);
    get(7'h50, 16'hffff, 16'h0000);
    put(7'h01, 16'h0003);
    refresh_all();
    refresh_all();
    get(7'h20, 16'h00ff, 16'h0050);
    get(7'h21, 16'hffff, 16'h0003);
    get(7'h22, 16'hffff, 16'h0000);
    // flash reload keeps memory writes shut for its whole length
    idle(6400);
    refresh_all();
    get(7'h20, 16'h00ff, 16'h0040);
    repeat (4)
    begin
      seed = xs(seed);
      ma = 13'(seed[28:16] % 13'd6000);
      mw(ma, seed[15:0]);
      mr(ma, seed[15:0]);
    end
    seed = xs(seed);
    mw(CMD_PTR, 16'h07cf);
    mw(CMD_DATA, seed[15:0]);
    mr(13'h176d, seed[15:0]);
    mw(OVR_ADDR, seed[31:16]);
    mr(OVR_ADDR, seed[31:16]);
    mw(13'h1902, 16'hffff);
    mr(13'h1902, 16'h0000);
    mw(13'h1950, 16'hffff);
    mr(13'h1950, 16'h0000);
    put(7'h41, 16'h0000);
    put(7'h42, 16'h1234);
    idle(2);
    get(7'h45, 16'h0002, 16'h0002);
    put(7'h45, 16'h0002);
    idle(2);
    get(7'h45, 16'h0002, 16'h0000);
    mw(13'h0100, 16'h1111);
    put(7'h00, 16'h0004);
    refresh_all();
    mw(13'h0100, 16'h2222);
    mr(13'h0100, 16'h1111);
    put(7'h00, 16'h0008);
    refresh_all();
    mw(13'h0100, 16'h3333);
    mr(13'h0100, 16'h3333);
    put(7'h00, 16'h0060);
    refresh_all();
    refresh_all();
    get(7'h26, 16'hffff, 16'h0001);
    get(7'h20, 16'h0003, 16'h0002);
    // monitor read lands inside the 16-cycle stop window
    put(7'h00, 16'h0002);
    put(7'h45, 16'h0001);
    idle(2);
    mr(13'h1900, 16'h0046);
    idle(50);
    // one axis held across two refreshes, snapshot taken mid-jog
    put(7'h01, 16'h0001);
    refresh_all();
    put(7'h01, 16'h0000);
    refresh_all();
    get(7'h21, 16'hffff, 16'h0001);
    get(7'h22, 16'hffff, 16'h0037);
    put(7'h00, 16'h0010);
    refresh_all();
    refresh_all();
    get(7'h22, 16'hffff, 16'h0000);
    get(7'h20, 16'h0080, 16'h0080);
    put(7'h00, 16'h0001);
    refresh_all();
    mw(13'h0100, 16'h4444);
    refresh_all();
    get(7'h20, 16'h0008, 16'h0008);
    idle(6400);
    mr(13'h0100, 16'h3333);
    // working copy changed after the save, so only a reload restores it
    mw(13'h0100, 16'h5555);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    idle(8);
    nrst_i <= 1'b1;
    idle(6400);
    mr(13'h0100, 16'h3333);
    idle(4);
    close_out();
  end
endmodule : test_plc_exchange_area
`default_nettype wire
